// File: core/fsp_status_protect.v
// Purpose: status register, write protect and bank map of a serial flash
// Assumes: link clock sampled by clk_sys; mode 0 serial, msb first
// Notes: one byte command, 4 byte address where the command needs one
// Operation
// - 128KB sectors: 64 per bank, 16 banks/die
// - 64KB sectors: 128 per bank, 16 banks/die
// - 64KB sector holds 2x32KB, 16x4KB subsectors
// - parameter header carries identifier FF00h; only its high byte FFh is served
// - status read and write by commands
// - disable bit and low pin lock status
// - top/bottom bit picks protected end
// - protect bits reject program/erase in region
// - write latch clear after power-up
// - busy bit high during write cycles
// - chip erase only with protect code zero
// - busy equals inverse of ready flag
// - code n protects 2^(n-1) blocks up to 11; all from 11 with 128KB sectors, only 15 all with 64KB
// - read other bank while one busy; the code has no array read, busy_bank only names the bank that is busy
`timescale 1ns/100ps
`default_nettype none
`include "fsp_defs.vh"
module fsp_status_protect
(
	// system
	input wire clk_sys,
	input wire rst,
	// serial link pins
	input wire sclk,
	input wire cs_n,
	input wire si,
	output reg so,
	output wire so_oe_n,
	input wire wp_n,
	// configuration and status
	input wire sect64,
	output reg [3:0] busy_bank,
	output reg [3:0] last_bank,
	output reg [11:0] last_sector,
	output reg [4:0] last_sub4k,
	output reg last_protected,
	output wire ready_flag
);
	localparam S_CMD = 4'b0001;
	localparam S_ADR = 4'b0010;
	localparam S_DAT = 4'b0100;
	localparam S_IGN = 4'b1000;
	reg [2:0] sck_s, cs_s, si_s, wp_s;
	reg sck_q, cs_q, wp_q;
	reg [3:0] st_r;
	reg [7:0] cmd_r;
	reg [7:0] sh_r;
	reg [5:0] bit_r;
	reg [31:0] adr_r;
	reg [7:0] sr_nv_r;
	reg wel_r;
	reg busy_r;
	reg [15:0] cnt_r;
	reg [7:0] pend_r;
	reg [1:0] op_r;
	reg [7:0] out_r;
	wire [7:0] status = {sr_nv_r[7:2], wel_r, busy_r};
	wire [15:0] sfdp_id = `FSP_SFDP_ID;
	wire sck_rise;
	wire sck_fall;
	wire sel;
	// majority-free filter: change accepted once stages 2 and 3 agree
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			sck_s <= 3'h0;
			cs_s <= 3'h7;
			si_s <= 3'h0;
			wp_s <= 3'h7;
			sck_q <= 1'b0;
			cs_q <= 1'b1;
			wp_q <= 1'b1;
		end
		else
		begin
			sck_s <= {sck_s[1:0], sclk};
			cs_s <= {cs_s[1:0], cs_n};
			si_s <= {si_s[1:0], si};
			wp_s <= {wp_s[1:0], wp_n};
			if (sck_s[1] == sck_s[2])
				sck_q <= sck_s[2];
			if (cs_s[1] == cs_s[2])
				cs_q <= cs_s[2];
			if (wp_s[1] == wp_s[2])
				wp_q <= wp_s[2];
		end
	end
	assign sck_rise = (sck_s[1] == sck_s[2]) && sck_s[2] && !sck_q;
	assign sck_fall = (sck_s[1] == sck_s[2]) && !sck_s[2] && sck_q;
	assign sel = !cs_q;
	assign so_oe_n = !(sel && st_r == S_DAT && (cmd_r == `FSP_CMD_RDSR ||
		cmd_r == `FSP_CMD_RDSFDP));
	assign ready_flag = !busy_r;
	// block index of an address in the current sector size
	function [11:0] fsp_block;
		input [31:0] a;
		input s64;
		begin
			if (s64)
				fsp_block = {1'b0, a[26:16]};
			else
				fsp_block = {1'b0, a[26:17]};
		end
	endfunction
	// protected region test; code 11+ is the whole array with 128KB
	function fsp_prot;
		input [11:0] blk;
		input [3:0] code;
		input tb;
		input s64;
		reg [11:0] n;
		reg [11:0] top;
		reg [11:0] cnt;
		begin
			n = 12'h000;
			top = s64 ? 12'h7FF : 12'h3FF;
			if (code == 4'h0)
				cnt = 12'h000;
			else if (!s64 && code > 4'hA)
				cnt = 12'h400;
			else if (s64 && code == 4'hF)
				cnt = 12'h800;
			else if (s64 && code > 4'hB)
				cnt = 12'h800 - (12'h800 >> (code - 4'hA));
			else
				cnt = 12'h001 << (code - 4'h1);
			n = tb ? blk : top - blk;
			fsp_prot = (code != 4'h0) && (n < cnt);
		end
	endfunction
	wire [3:0] bp = {sr_nv_r[`FSP_SR_BP3], sr_nv_r[`FSP_SR_BPH:`FSP_SR_BPL]};
	wire [11:0] blk_now = fsp_block(adr_r, sect64);
	wire hw_lock = sr_nv_r[`FSP_SR_SWD] && !wp_q;
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			st_r <= S_CMD;
			cmd_r <= 8'h00;
			sh_r <= 8'h00;
			bit_r <= 6'h00;
			adr_r <= 32'h0;
			sr_nv_r <= `FSP_SR_RESET;
			wel_r <= 1'b0;
			busy_r <= 1'b0;
			cnt_r <= 16'h0;
			pend_r <= 8'h00;
			op_r <= 2'h0;
			out_r <= 8'h00;
			so <= 1'b0;
			busy_bank <= 4'h0;
			last_bank <= 4'h0;
			last_sector <= 12'h000;
			last_sub4k <= 5'h00;
			last_protected <= 1'b0;
		end
		else
		begin
			// internal cycle; latch and busy drop only at its end
			if (busy_r)
			begin
				if (cnt_r == 16'h0001)
				begin
					if (op_r == 2'h1)
						sr_nv_r <= pend_r & `FSP_SR_NV_MASK;
					busy_r <= 1'b0;
					wel_r <= 1'b0;
				end
				cnt_r <= cnt_r - 16'h0001;
			end
			if (!sel)
			begin
				st_r <= S_CMD;
				bit_r <= 6'h00;
			end
			else if (sck_fall && !so_oe_n)
			begin
				so <= out_r[7];
				out_r <= {out_r[6:0], out_r[7]};
			end
			else if (sck_rise)
			begin
				sh_r <= {sh_r[6:0], si_s[2]};
				bit_r <= bit_r + 6'h01;
				case (st_r)
				S_CMD:
					if (bit_r == 6'h07)
					begin
						cmd_r <= {sh_r[6:0], si_s[2]};
						bit_r <= 6'h00;
						st_r <= S_DAT;
						// first bit leaves on the next fall, as mode 0 wants
						out_r <= status;
						case ({sh_r[6:0], si_s[2]})
						`FSP_CMD_WREN:
							if (!busy_r)
								wel_r <= 1'b1;
						`FSP_CMD_WRDI:
							if (!busy_r)
								wel_r <= 1'b0;
						`FSP_CMD_PP, `FSP_CMD_SE, `FSP_CMD_SSE4,
						`FSP_CMD_SSE32, `FSP_CMD_RDSFDP:
							st_r <= S_ADR;
						default:
							;
						endcase
					end
				S_ADR:
					begin
						adr_r <= {adr_r[30:0], si_s[2]};
						if (bit_r == 6'h1F)
						begin
							st_r <= S_DAT;
							bit_r <= 6'h00;
							// only the identifier's high byte is served
							out_r <= sfdp_id[15:8];
						end
					end
				S_DAT:
					if (bit_r == 6'h07)
						bit_r <= 6'h00;
				default:
					st_r <= S_IGN;
				endcase
			end
			// command acts at deselect, once the command and any address bits are in; data bits are not counted
			if (cs_s[1] == cs_s[2] && cs_s[2] && !cs_q && st_r == S_DAT &&
				!busy_r && wel_r)
			begin
				case (cmd_r)
				`FSP_CMD_WRSR, `FSP_CMD_WRNV:
					if (!(hw_lock && cmd_r == `FSP_CMD_WRSR))
					begin
						busy_r <= 1'b1;
						op_r <= (cmd_r == `FSP_CMD_WRSR) ? 2'h1 : 2'h2;
						pend_r <= sh_r;
						cnt_r <= `FSP_WR_CYCLES;
					end
				`FSP_CMD_PP, `FSP_CMD_SE, `FSP_CMD_SSE4, `FSP_CMD_SSE32:
					if (!fsp_prot(blk_now, bp, sr_nv_r[`FSP_SR_TB], sect64))
					begin
						busy_r <= 1'b1;
						op_r <= 2'h3;
						cnt_r <= (cmd_r == `FSP_CMD_PP) ? `FSP_PG_CYCLES :
							`FSP_ER_CYCLES;
						busy_bank <= sect64 ? blk_now[10:7] :
							blk_now[9:6];
					end
				`FSP_CMD_CE:
					if (bp == 4'h0)
					begin
						busy_r <= 1'b1;
						op_r <= 2'h3;
						cnt_r <= `FSP_ER_CYCLES;
					end
				default:
					;
				endcase
			end
			// bank, sector and 4KB subsector of the last address
			last_sector <= blk_now;
			last_bank <= sect64 ? blk_now[10:7] : blk_now[9:6];
			if (sect64)
				last_bank <= blk_now[10:7];
			last_sub4k <= sect64 ? {1'b0, adr_r[15:12]} : adr_r[16:12];
			if (sect64)
				last_sub4k <= {1'b0, adr_r[15:12]};
			last_protected <= fsp_prot(blk_now, bp, sr_nv_r[`FSP_SR_TB],
				sect64);
		end
	end
endmodule // fsp_status_protect
`default_nettype wire

// File: pkg/fsp_defs.vh
// Purpose: constants for the flash status and protection block
// Assumes: included by core/fsp_status_protect.v
// Notes: command codes and cycle counts are plain defaults
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH
`define FSP_SR_SWD 7
`define FSP_SR_BP3 6
`define FSP_SR_TB 5
`define FSP_SR_BPH 4
`define FSP_SR_BPL 2
`define FSP_SR_WEL 1
`define FSP_SR_BUSY 0
`define FSP_SR_NV_MASK 8'hFC
`define FSP_SR_RESET 8'h00
`define FSP_CMD_WREN 8'h06
`define FSP_CMD_WRDI 8'h04
`define FSP_CMD_RDSR 8'h05
`define FSP_CMD_WRSR 8'h01
`define FSP_CMD_WRNV 8'hB1
`define FSP_CMD_PP 8'h02
`define FSP_CMD_SE 8'hD8
`define FSP_CMD_SSE4 8'h20
`define FSP_CMD_SSE32 8'h52
`define FSP_CMD_CE 8'hC7
`define FSP_CMD_RDSFDP 8'h5A
`define FSP_SFDP_ID 16'hFF00
`define FSP_WR_CYCLES 16'h0040
`define FSP_PG_CYCLES 16'h0100
`define FSP_ER_CYCLES 16'h0400
`endif

// File: test/fsp_host.sv
// Purpose: host controller model
// Assumes: eight system clocks per link half period
// Notes: si shows its inverse while deselected
`timescale 1ns/100ps
`default_nettype none
module fsp_host
(
	// serial link
	output var logic sclk,
	output var logic cs_n,
	output var logic si,
	input wire logic so
);
	initial
	begin
		sclk = 0;
		cs_n = 1;
		si = 0;
	end
	// msb first; rd keeps the last eight bits seen on so
	task automatic frame(input logic [47:0] d, input int n,
		output logic [7:0] rd);
		cs_n = 0;
		for (int i = n - 1; i >= 0; i--)
		begin
			si = d[i];
			#200 sclk = 1;
			rd = {rd[6:0], so};
			#200 sclk = 0;
		end
		#100 cs_n = 1;
		si = ~si;
		#2000;
	endtask
endmodule // fsp_host
`default_nettype wire

// File: test/fsp_status_protect_chk.sv
// Purpose: port checker
// Assumes: busy shows only as ready_flag
// Notes: map checks allow two cycles of lag
`timescale 1ns/100ps
`default_nettype none
module fsp_chk
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// watched ports
	input wire logic cs_n,
	input wire logic so_oe_n,
	input wire logic sect64,
	input wire logic ready_flag,
	input wire logic [3:0] last_bank,
	input wire logic [11:0] last_sector
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// erase is the longest cycle; a counter bounds it
	logic [10:0] busy_cnt_r;
	always @(posedge clk_sys)
	begin
		if (rst || ready_flag)
			busy_cnt_r <= 11'h000;
		else if (busy_cnt_r != 11'h7FF)
			busy_cnt_r <= busy_cnt_r + 11'h001;
	end
	a_reset_state: assert property (disable iff (1'b0)
		rst |=> ready_flag && so_oe_n) else $error("reset");
	a_oe_idle: assert property (
		cs_n [*8] |-> so_oe_n) else $error("so idle");
	a_oe_frame: assert property (
		$fell(so_oe_n) |-> !cs_n) else $error("so frame");
	a_busy_min: assert property (
		$fell(ready_flag) |-> !ready_flag [*8]) else $error("busy short");
	a_busy_max: assert property (
		busy_cnt_r < 11'h44C) else $error("busy long");
	a_busy_cause: assert property (
		$fell(ready_flag) |-> $past(cs_n, 2)) else $error("busy cause");
	a_bank_map: assert property (
		$changed(last_sector) |-> ##[0:2] last_bank == (sect64 ?
		last_sector[10:7] : last_sector[9:6])) else $error("bank");
	a_map_hold: assert property (
		cs_n [*8] ##0 $stable(sect64) |=> $stable(last_sector))
		else $error("map moved");
	c_busy: cover property ($fell(ready_flag));
	c_read: cover property ($fell(so_oe_n));
	c_map64: cover property ($changed(last_sector) && sect64);
endmodule // fsp_chk
bind fsp_status_protect fsp_chk u_chk (.clk_sys, .rst, .cs_n, .so_oe_n,
	.sect64, .ready_flag, .last_bank, .last_sector);
`default_nettype wire

// File: test/fsp_status_protect_tb.sv
// Purpose: bench
// Assumes: frames come from fsp_host
// Notes: 5Ah frames shift an address; the 48-bit ones also read one byte
`timescale 1ns/100ps
`default_nettype none
module fsp_status_protect_tb;
	logic clk_sys = 0, rst = 1, wp_n = 1, sect64 = 0;
	wire sclk, cs_n, si, so, so_oe_n, last_protected, ready_flag;
	wire [3:0] busy_bank, last_bank;
	wire [11:0] last_sector;
	wire [4:0] last_sub4k;
	int n_mismatch = 0, checked = 0, i;
	logic [7:0] rd;
	// layout, address, bank, sector
	logic [44:0] rows [7] = '{{1'b0, 28'h0, 4'h0, 12'h0},
		{1'b0, 28'h7FFFFF, 4'h0, 12'h3F}, {1'b0, 28'h800000, 4'h1, 12'h40},
		{1'b0, 28'h7FFFFFF, 4'hF, 12'h3FF}, {1'b1, 28'hFFFFFF, 4'h1, 12'hFF},
		{1'b1, 28'h7800000, 4'hF, 12'h780}, {1'b1, 28'h7FFFFF, 4'h0, 12'h7F}};
	fsp_status_protect u_dut (.clk_sys, .rst, .sclk, .cs_n, .si, .so,
		.so_oe_n, .wp_n, .sect64, .busy_bank, .last_bank, .last_sector,
		.last_sub4k, .last_protected, .ready_flag);
	fsp_host u_host (.sclk, .cs_n, .si, .so);
	initial forever #12.5 clk_sys = ~clk_sys;
	initial
	begin
		#2000000 n_mismatch++;
		report_and_stop;
	end
	task chk(input string nm, input logic [11:0] e, g);
		checked++;
		if (g !== e)
		begin
			$display("ERROR %s exp %h got %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	task st(input logic [7:0] e);
		u_host.frame(48'h0500, 16, rd);
		chk("status", e, rd);
	endtask
	task op(input logic [47:0] d, input int n);
		u_host.frame(48'h06, 8, rd);
		u_host.frame(d, n, rd);
	endtask
	task report_and_stop;
		if (n_mismatch == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(negedge clk_sys);
		rst = 0;
		repeat (4) @(negedge clk_sys);
		st(8'h00);
		for (i = 0; i < 7; i++)
		begin
			@(negedge clk_sys) sect64 = rows[i][44];
			u_host.frame({8'h5A, 4'h0, rows[i][43:16], 8'h00}, 48, rd);
			chk("sfdp", 12'h0FF, rd);
			chk("bank", rows[i][15:12], last_bank);
			chk("sector", rows[i][11:0], last_sector);
			chk("sub4k", rows[i][31:28], last_sub4k[3:0]);
		end
		@(negedge clk_sys) sect64 = 0;
		op({8'h01, 8'h04}, 16);
		st(8'h04);
		u_host.frame({8'h5A, 32'h07FE0000}, 40, rd);
		chk("prot", 12'h001, last_protected);
		u_host.frame({8'h5A, 32'h07FDFFFF}, 40, rd);
		chk("prot", 12'h000, last_protected);
		op({8'h02, 32'h07FE0000, 8'h5A}, 48);
		chk("pp", 12'h001, ready_flag);
		op(8'hC7, 8);
		chk("ce", 12'h001, ready_flag);
		op({8'h01, 8'hA4}, 16);
		st(8'hA4);
		u_host.frame({8'h5A, 32'h0001FFFF}, 40, rd);
		chk("prot", 12'h001, last_protected);
		@(negedge clk_sys) wp_n = 0;
		op({8'h01, 8'h00}, 16);
		u_host.frame(48'h04, 8, rd);
		st(8'hA4);
		@(negedge clk_sys) wp_n = 1;
		op({8'h01, 8'h00}, 16);
		st(8'h00);
		u_host.frame({8'h01, 8'h04}, 16, rd);
		st(8'h00);
		op(8'hC7, 8);
		chk("ce", 12'h000, ready_flag);
		st(8'h03);
		for (i = 0; i < 2000 && ready_flag !== 1'b1; i++)
			@(posedge clk_sys);
		@(negedge clk_sys);
		st(8'h00);
		op({8'h20, 32'h04A00000}, 40);
		chk("erase", 12'h000, ready_flag);
		chk("busy_bank", 12'h009, busy_bank);
		report_and_stop;
	end
endmodule // fsp_status_protect_tb
`default_nettype wire
